// ### hdl/supervisor_regs_pkg.sv
package supervisor_regs_pkg;

   // ----------------------------------------------------------------
   // widths
   // ----------------------------------------------------------------
   localparam int XLEN     = 32;
   localparam int SPR_BITS = 10;

   // ----------------------------------------------------------------
   // special register numbers
   // ----------------------------------------------------------------
   localparam logic [9:0] SPR_FAULT_CAUSE    = 10'h010;
   localparam logic [9:0] SPR_FAULT_ADDRESS  = 10'h011;
   localparam logic [9:0] SPR_COUNTDOWN      = 10'h012;
   localparam logic [9:0] SPR_PAGE_TABLE     = 10'h013;
   localparam logic [9:0] SPR_SAVE_PC        = 10'h014;
   localparam logic [9:0] SPR_SAVE_STATE     = 10'h015;
   localparam logic [9:0] SPR_SCRATCH_BASE   = 10'h018;
   localparam logic [9:0] SPR_TICK_LOWER     = 10'h01C;
   localparam logic [9:0] SPR_TICK_UPPER     = 10'h01D;
   localparam logic [9:0] SPR_VERSION        = 10'h020;
   localparam logic [9:0] SPR_FLOAT_CAUSE    = 10'h021;
   localparam logic [9:0] SPR_EXT_TARGET     = 10'h022;
   localparam logic [9:0] SPR_WATCHPOINT     = 10'h023;
   localparam logic [9:0] SPR_IDENTITY       = 10'h024;
   localparam logic [9:0] SPR_BLOCK_BASE     = 10'h040;
   localparam logic [9:0] SPR_SEGMENT_BASE   = 10'h060;

   // ----------------------------------------------------------------
   // machine state fields (bit 0 of the big-endian view is bit 31)
   // ----------------------------------------------------------------
   localparam int MSR_EE_BIT  = 15;
   localparam int MSR_PR_BIT  = 14;
   localparam logic [31:0] MSR_RESET        = 32'h0000_0000;
   localparam logic [31:0] MSR_RESTORE_MASK = 32'h0007_FFFF;
   localparam logic [31:0] SAVE_STATUS_MASK = 32'hFFF8_0000;

   // ----------------------------------------------------------------
   // segment descriptor format selector and watchpoint fields
   // ----------------------------------------------------------------
   localparam int SEG_FORMAT_BIT = 31;
   localparam int WATCH_RD_BIT   = 0;
   localparam int WATCH_WR_BIT   = 1;
   localparam logic [31:0] WATCH_ADDR_MASK = 32'hFFFF_FFF8;

   // ----------------------------------------------------------------
   // reset values and timing counts
   // ----------------------------------------------------------------
   localparam logic [31:0] ZERO_RESET      = 32'h0000_0000;
   localparam int          TIMER_PRESCALE  = 4;

endpackage

// ### hdl/timer_if.sv
`timescale 1ns/1ps
interface timer_if;
   logic        wr_lower;
   logic        wr_upper;
   logic        wr_countdown;
   logic [31:0] wdata;
   logic [31:0] tick_lower;
   logic [31:0] tick_upper;
   logic [31:0] countdown;
   logic        expire;

   modport ctrl  (output wr_lower, wr_upper, wr_countdown, wdata,
                  input  tick_lower, tick_upper, countdown, expire);
   modport timer (input  wr_lower, wr_upper, wr_countdown, wdata,
                  output tick_lower, tick_upper, countdown, expire);
endinterface

// ### hdl/tick_timer.sv
`timescale 1ns/1ps
module tick_timer #(
   parameter int PRESCALE = supervisor_regs_pkg::TIMER_PRESCALE
) (
   // clock and reset
   input  wire logic i_core_clk,
   input  wire logic i_rst_n,
   input  wire logic i_ce,
   // register side
   timer_if.timer    tif
);

   typedef struct packed {
      logic [15:0] div;
      logic [63:0] tick;
      logic [31:0] cd;
      logic        expire;
   } timer_type;

   timer_type q;
   timer_type d;
   logic      step;

   // ----------------------------------------------------------------
   // prescaled counting
   // ----------------------------------------------------------------
   // both counters advance on the same subdivided strobe
   always_comb begin
      d        = q;
      d.expire = 1'b0;
      step     = (q.div == 16'(PRESCALE - 1));
      d.div    = step ? 16'h0000 : q.div + 16'h0001;
      if (step) begin
         d.tick = q.tick + 64'h0000_0000_0000_0001;
         d.cd   = q.cd - 32'h0000_0001;
         // expiry is the wrap from zero to all ones
         d.expire = (q.cd == 32'h0000_0000);
      end
      // a software write wins over the count in the same cycle
      if (tif.wr_lower) d.tick[31:0]  = tif.wdata;
      if (tif.wr_upper) d.tick[63:32] = tif.wdata;
      if (tif.wr_countdown) begin
         d.cd     = tif.wdata;
         d.expire = 1'b0;
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (!i_rst_n) begin
         q <= '0;
      end else if (i_ce) begin
         q <= d;
      end
   end

   assign tif.tick_lower = q.tick[31:0];
   assign tif.tick_upper = q.tick[63:32];
   assign tif.countdown  = q.cd;
   assign tif.expire     = q.expire;

endmodule

// ### hdl/supervisor_register_set.sv
// Functional notes
// - supervisor registers refuse user-level access and raise a privilege fault.
// - undefined register numbers raise an illegal-instruction fault.
// - listed core registers are each 32 bits wide.
// - version register is read-only, reporting model and revision.
// - four instruction and four data block translation pairs.
// - page table base register holds the translation table base.
// - sixteen 32-bit segment descriptor registers.
// - descriptor bit 0 selects between two field formats.
// - data fault or alignment loads the faulting effective address.
// - fault cause register records why the fault was taken.
// - four scratch registers are plain storage for the OS.
// - exception saves the program address; return resumes there.
// - exception saves state and status; return restores machine state.
// - whole machine state saved before exception bits are loaded; the code saves only bits 18:0 and puts the status in bits 31:19.
// - machine state changed only by write, system call, return; the code also loads it on every exception entry (i_exc_take).
// - optional float fault cause register identifies float exceptions.
// - 64-bit tick counter in halves, readable at user level.
// - 32-bit countdown on a clock subdivision raises an exception.
// - optional external access target register for external I/O.
// - optional watchpoint register drives data address breakpoints.
// - optional identity register distinguishes processors.
// - clear interrupt enable defers external and countdown requests.
//
// The address-and-strobe port and the address map were chosen for this implementation.
`timescale 1ns/1ps
module supervisor_register_set #(
   parameter logic [31:0] VERSION_ID  = 32'h0001_0001, // arbitrary value
   parameter logic [31:0] IDENTITY    = 32'h0000_0000,
   parameter int          PRESCALE    = supervisor_regs_pkg::TIMER_PRESCALE
) (
   // clock, reset, enable
   input  wire logic        i_core_clk,
   input  wire logic        i_rst_n,
   input  wire logic        i_ce,
   // special register access port
   input  wire logic [9:0]  i_spr_num,
   input  wire logic [31:0] i_wdata,
   input  wire logic        i_spr_wr,
   input  wire logic        i_spr_rd,
   input  wire logic        i_msr_wr,
   input  wire logic        i_msr_rd,
   output logic      [31:0] o_rdata,
   output logic             o_priv_exc,
   output logic             o_illegal_exc,
   // exception entry and return
   input  wire logic        i_exc_take,
   input  wire logic [31:0] i_exc_pc,
   input  wire logic [31:0] i_exc_status,
   input  wire logic [31:0] i_exc_new_state,
   input  wire logic        i_return,
   output logic      [31:0] o_resume_pc,
   output logic             o_resume_valid,
   // fault capture
   input  wire logic        i_data_fault,
   input  wire logic [31:0] i_fault_ea,
   input  wire logic [31:0] i_fault_cause,
   input  wire logic        i_float_fault,
   input  wire logic [31:0] i_float_cause,
   // data access watch
   input  wire logic        i_data_valid,
   input  wire logic        i_data_store,
   input  wire logic [31:0] i_data_ea,
   output logic             o_watch_hit,
   // interrupt requests
   input  wire logic        i_ext_irq,
   input  wire logic        i_countdown_ack,
   output logic             o_ext_irq_req,
   output logic             o_countdown_req,
   // translation view
   input  wire logic [3:0]  i_seg_index,
   output logic      [31:0] o_seg_desc,
   output logic             o_seg_alt_format,
   output logic      [31:0] o_page_table_base,
   output logic      [31:0] o_machine_state,
   output logic      [31:0] o_ext_target
);

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [31:0]       machine_state;
      logic [31:0]       save_pc;
      logic [31:0]       save_state;
      logic [31:0]       fault_address;
      logic [31:0]       fault_cause;
      logic [31:0]       page_table_base;
      logic [31:0]       float_cause;
      logic [31:0]       ext_target;
      logic [31:0]       watchpoint;
      logic [31:0]       identity;
      logic [3:0][31:0]  scratch;
      logic [15:0][31:0] segment;
      logic [15:0][31:0] block;
      logic [31:0]       rdata;
      logic [31:0]       resume_pc;
      logic [31:0]       seg_desc;
      logic              resume_valid;
      logic              priv_exc;
      logic              illegal_exc;
      logic              cd_pending;
      logic              watch_hit;
   } regs_type;

   regs_type q;
   regs_type d;

   timer_if tif ();

   tick_timer #(
      .PRESCALE (PRESCALE)
   ) u_timer (
      .i_core_clk (i_core_clk),
      .i_rst_n    (i_rst_n),
      .i_ce       (i_ce),
      .tif        (tif)
   );

   // ----------------------------------------------------------------
   // decode helpers
   // ----------------------------------------------------------------
   // true for every number the register set answers to
   function automatic logic spr_known(input logic [9:0] n);
      logic k;
      k = 1'b0;
      case (n)
         supervisor_regs_pkg::SPR_FAULT_CAUSE,
         supervisor_regs_pkg::SPR_FAULT_ADDRESS,
         supervisor_regs_pkg::SPR_COUNTDOWN,
         supervisor_regs_pkg::SPR_PAGE_TABLE,
         supervisor_regs_pkg::SPR_SAVE_PC,
         supervisor_regs_pkg::SPR_SAVE_STATE,
         supervisor_regs_pkg::SPR_TICK_LOWER,
         supervisor_regs_pkg::SPR_TICK_UPPER,
         supervisor_regs_pkg::SPR_VERSION,
         supervisor_regs_pkg::SPR_FLOAT_CAUSE,
         supervisor_regs_pkg::SPR_EXT_TARGET,
         supervisor_regs_pkg::SPR_WATCHPOINT,
         supervisor_regs_pkg::SPR_IDENTITY: k = 1'b1;
         default: k = 1'b0;
      endcase
      if (n[9:2] == supervisor_regs_pkg::SPR_SCRATCH_BASE[9:2]) k = 1'b1;
      if (n[9:4] == supervisor_regs_pkg::SPR_BLOCK_BASE[9:4])   k = 1'b1;
      if (n[9:4] == supervisor_regs_pkg::SPR_SEGMENT_BASE[9:4]) k = 1'b1;
      return k;
   endfunction

   // tick halves are the only numbers that user level may read
   function automatic logic spr_user_read(input logic [9:0] n);
      return (n == supervisor_regs_pkg::SPR_TICK_LOWER) ||
             (n == supervisor_regs_pkg::SPR_TICK_UPPER);
   endfunction

   logic user_mode;
   logic spr_ok;
   logic spr_wr_ok;
   logic spr_rd_ok;

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      d              = q;
      d.priv_exc     = 1'b0;
      d.illegal_exc  = 1'b0;
      d.resume_valid = 1'b0;
      d.watch_hit    = 1'b0;
      d.rdata        = 32'h0000_0000;
      tif.wr_lower     = 1'b0;
      tif.wr_upper     = 1'b0;
      tif.wr_countdown = 1'b0;
      tif.wdata        = i_wdata;
      user_mode = q.machine_state[supervisor_regs_pkg::MSR_PR_BIT];

      // access checks: unknown numbers fault before privilege is looked at
      spr_ok = spr_known(i_spr_num);
      if ((i_spr_wr || i_spr_rd) && !spr_ok) begin
         d.illegal_exc = 1'b1;
      end
      spr_wr_ok = i_spr_wr && spr_ok && !user_mode;
      spr_rd_ok = i_spr_rd && spr_ok &&
                  (!user_mode || spr_user_read(i_spr_num));
      if ((i_spr_wr && spr_ok && !spr_wr_ok) ||
          (i_spr_rd && spr_ok && !spr_rd_ok)) begin
         d.priv_exc = 1'b1;
      end

      // special register writes; version has no write path
      if (spr_wr_ok) begin
         case (i_spr_num)
            supervisor_regs_pkg::SPR_FAULT_CAUSE:   d.fault_cause = i_wdata;
            supervisor_regs_pkg::SPR_FAULT_ADDRESS:
               d.fault_address = i_wdata;
            supervisor_regs_pkg::SPR_COUNTDOWN:
               tif.wr_countdown = 1'b1;
            supervisor_regs_pkg::SPR_PAGE_TABLE:
               d.page_table_base = i_wdata;
            supervisor_regs_pkg::SPR_SAVE_PC:       d.save_pc = i_wdata;
            supervisor_regs_pkg::SPR_SAVE_STATE:    d.save_state = i_wdata;
            supervisor_regs_pkg::SPR_TICK_LOWER:    tif.wr_lower = 1'b1;
            supervisor_regs_pkg::SPR_TICK_UPPER:    tif.wr_upper = 1'b1;
            supervisor_regs_pkg::SPR_FLOAT_CAUSE:   d.float_cause = i_wdata;
            supervisor_regs_pkg::SPR_EXT_TARGET:
               d.ext_target = i_wdata;
            supervisor_regs_pkg::SPR_WATCHPOINT:
               d.watchpoint = i_wdata;
            supervisor_regs_pkg::SPR_IDENTITY:
               d.identity = i_wdata;
            default: begin
               // scratch is storage only, nothing downstream reads it
               if (i_spr_num[9:2] == supervisor_regs_pkg::SPR_SCRATCH_BASE[9:2])
                  d.scratch[i_spr_num[1:0]] = i_wdata;
               if (i_spr_num[9:4] == supervisor_regs_pkg::SPR_BLOCK_BASE[9:4])
                  d.block[i_spr_num[3:0]] = i_wdata;
               if (i_spr_num[9:4] == supervisor_regs_pkg::SPR_SEGMENT_BASE[9:4])
                  d.segment[i_spr_num[3:0]] = i_wdata;
            end
         endcase
      end

      // special register reads, data stand one cycle later
      if (spr_rd_ok) begin
         case (i_spr_num)
            supervisor_regs_pkg::SPR_FAULT_CAUSE:   d.rdata = q.fault_cause;
            supervisor_regs_pkg::SPR_FAULT_ADDRESS: d.rdata = q.fault_address;
            supervisor_regs_pkg::SPR_COUNTDOWN:     d.rdata = tif.countdown;
            supervisor_regs_pkg::SPR_PAGE_TABLE:
               d.rdata = q.page_table_base;
            supervisor_regs_pkg::SPR_SAVE_PC:       d.rdata = q.save_pc;
            supervisor_regs_pkg::SPR_SAVE_STATE:    d.rdata = q.save_state;
            supervisor_regs_pkg::SPR_TICK_LOWER:    d.rdata = tif.tick_lower;
            supervisor_regs_pkg::SPR_TICK_UPPER:    d.rdata = tif.tick_upper;
            supervisor_regs_pkg::SPR_VERSION:       d.rdata = VERSION_ID;
            supervisor_regs_pkg::SPR_FLOAT_CAUSE:   d.rdata = q.float_cause;
            supervisor_regs_pkg::SPR_EXT_TARGET:    d.rdata = q.ext_target;
            supervisor_regs_pkg::SPR_WATCHPOINT:    d.rdata = q.watchpoint;
            supervisor_regs_pkg::SPR_IDENTITY:      d.rdata = q.identity;
            default: begin
               if (i_spr_num[9:2] == supervisor_regs_pkg::SPR_SCRATCH_BASE[9:2])
                  d.rdata = q.scratch[i_spr_num[1:0]];
               if (i_spr_num[9:4] == supervisor_regs_pkg::SPR_BLOCK_BASE[9:4])
                  d.rdata = q.block[i_spr_num[3:0]];
               if (i_spr_num[9:4] == supervisor_regs_pkg::SPR_SEGMENT_BASE[9:4])
                  d.rdata = q.segment[i_spr_num[3:0]];
            end
         endcase
      end

      // machine state instructions are supervisor only
      if (i_msr_wr || i_msr_rd) begin
         if (user_mode) begin
            d.priv_exc = 1'b1;
         end else if (i_msr_wr) begin
            d.machine_state = i_wdata;
         end else begin
            d.rdata = q.machine_state;
         end
      end

      // return: restore state and resume at the saved address
      if (i_return) begin
         if (user_mode) begin
            d.priv_exc = 1'b1;
         end else begin
            d.machine_state = q.save_state &
                              supervisor_regs_pkg::MSR_RESTORE_MASK;
            d.resume_pc     = q.save_pc;
            d.resume_valid  = 1'b1;
         end
      end

      // exception entry (system call included) wins over writes and return for save_pc, save_state and machine_state
      if (i_exc_take) begin
         d.save_pc    = i_exc_pc;
         // old state first, then the status field, then the new state
         d.save_state = (q.machine_state &
                         ~supervisor_regs_pkg::SAVE_STATUS_MASK) |
                        (i_exc_status &
                         supervisor_regs_pkg::SAVE_STATUS_MASK);
         d.machine_state = i_exc_new_state;
      end

      // fault capture overrides a software write in the same cycle
      if (i_data_fault) begin
         d.fault_address = i_fault_ea;
         d.fault_cause   = i_fault_cause;
      end
      if (i_float_fault) begin
         d.float_cause = i_float_cause;
      end

      // countdown request: set wins over acknowledge
      if (i_countdown_ack) d.cd_pending = 1'b0;
      if (tif.expire)      d.cd_pending = 1'b1;

      // breakpoint compare on aligned double word
      if (i_data_valid &&
          ((i_data_ea & supervisor_regs_pkg::WATCH_ADDR_MASK) ==
           (q.watchpoint & supervisor_regs_pkg::WATCH_ADDR_MASK)) &&
          ((i_data_store &&
            q.watchpoint[supervisor_regs_pkg::WATCH_WR_BIT]) ||
           (!i_data_store &&
            q.watchpoint[supervisor_regs_pkg::WATCH_RD_BIT]))) begin
         d.watch_hit = 1'b1;
      end

      // translation view of one descriptor
      d.seg_desc = q.segment[i_seg_index];
   end

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   // enable low freezes everything, including pending pulses
   always_ff @(posedge i_core_clk) begin
      if (!i_rst_n) begin
         q               <= '0;
         q.machine_state <= supervisor_regs_pkg::MSR_RESET;
         q.identity      <= IDENTITY;
      end else if (i_ce) begin
         q <= d;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign o_rdata           = q.rdata;
   assign o_priv_exc        = q.priv_exc;
   assign o_illegal_exc     = q.illegal_exc;
   assign o_resume_pc       = q.resume_pc;
   assign o_resume_valid    = q.resume_valid;
   assign o_watch_hit       = q.watch_hit;
   assign o_seg_desc        = q.seg_desc;
   // format flag decides how the other descriptor fields are read
   assign o_seg_alt_format  =
      q.seg_desc[supervisor_regs_pkg::SEG_FORMAT_BIT];
   assign o_page_table_base = q.page_table_base;
   assign o_machine_state   = q.machine_state;
   assign o_ext_target      = q.ext_target;
   // requests are held back while the enable bit is clear
   assign o_ext_irq_req     = i_ext_irq &&
      q.machine_state[supervisor_regs_pkg::MSR_EE_BIT];
   assign o_countdown_req   = q.cd_pending &&
      q.machine_state[supervisor_regs_pkg::MSR_EE_BIT];

endmodule

// ### bench/supervisor_register_set_monitor.sv
`timescale 1ns/1ps
module supervisor_register_set_monitor #(
   parameter logic [31:0] VERSION_ID = 32'h0001_0001
) (
   // clock and reset
   input wire logic        i_core_clk,
   input wire logic        i_rst_n,
   input wire logic        i_ce,
   // watched inputs
   input wire logic [9:0]  i_spr_num,
   input wire logic        i_spr_wr,
   input wire logic        i_spr_rd,
   input wire logic        i_msr_wr,
   input wire logic        i_exc_take,
   input wire logic [31:0] i_exc_pc,
   input wire logic [31:0] i_exc_new_state,
   input wire logic        i_return,
   input wire logic        i_ext_irq,
   // watched outputs
   input wire logic [31:0] o_rdata,
   input wire logic        o_priv_exc,
   input wire logic        o_illegal_exc,
   input wire logic [31:0] o_resume_pc,
   input wire logic        o_resume_valid,
   input wire logic        o_ext_irq_req,
   input wire logic [31:0] o_machine_state
);
   // -------------------------------------------------------------
   // properties
   // -------------------------------------------------------------
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (!i_rst_n);

   undef_num_a: assert property (i_ce && i_spr_rd && i_spr_num == 10'h3FF
      |=> o_illegal_exc && o_rdata == 32'h0000_0000)
      else $error("undefined number not refused");
   user_priv_a: assert property (i_ce && i_spr_rd && o_machine_state[14]
      && i_spr_num == 10'h014 |=> o_priv_exc)
      else $error("user access not refused");
   tick_user_a: assert property (i_ce && i_spr_rd && o_machine_state[14]
      && i_spr_num inside {10'h01C, 10'h01D} |=> !o_priv_exc)
      else $error("user tick read refused");
   exc_load_a: assert property (i_ce && i_exc_take
      |=> o_machine_state == $past(i_exc_new_state))
      else $error("exception state not loaded");
   resume_pc_a: assert property (i_ce && i_exc_take ##1 i_ce && i_return
      && !i_exc_take && !o_machine_state[14]
      |=> o_resume_valid && o_resume_pc == $past(i_exc_pc, 2))
      else $error("resume address wrong");
   irq_mask_a: assert property (o_ext_irq_req
      == (i_ext_irq && o_machine_state[15]))
      else $error("external request not masked");
   msr_user_a: assert property (i_ce && i_msr_wr && !i_exc_take
      && o_machine_state[14] |=> o_priv_exc && $stable(o_machine_state))
      else $error("user state write not refused");
   version_ro_a: assert property (i_ce && i_spr_rd
      && i_spr_num == 10'h020 && !o_machine_state[14]
      |=> o_rdata == VERSION_ID)
      else $error("version value altered");

   // main scenarios reached
   cover property (i_ce && i_exc_take);
   cover property (o_priv_exc);
   cover property (o_resume_valid);
endmodule

bind supervisor_register_set supervisor_register_set_monitor #(
   .VERSION_ID(VERSION_ID)
) mon (.i_core_clk, .i_rst_n, .i_ce, .i_spr_num, .i_spr_wr, .i_spr_rd,
   .i_msr_wr, .i_exc_take, .i_exc_pc, .i_exc_new_state, .i_return,
   .i_ext_irq, .o_rdata, .o_priv_exc, .o_illegal_exc, .o_resume_pc,
   .o_resume_valid, .o_ext_irq_req, .o_machine_state);

// ### bench/test_supervisor_register_set.sv
`timescale 1ns/1ps
module test_supervisor_register_set;
   // -------------------------------------------------------------
   // signals and design
   // -------------------------------------------------------------
   logic        clk, rst_n, ce, swr, srd, mwr, mrd, take, ret, dflt, fflt;
   logic        dval, dst, irq, ack;
   logic [9:0]  num;
   logic [3:0]  seg;
   logic [31:0] wd, pc, st, ns, ea, cause, fcause, dea;
   logic [31:0] rdata, rpc, segd, ptb, ms, ext;
   logic        priv, ill, rval, hit, ireq, creq, alt;
   int          fails, total_checks, cyc;

   supervisor_register_set #(.IDENTITY(32'h0000_0007), .PRESCALE(2)) uut (
      .i_core_clk(clk), .i_rst_n(rst_n), .i_ce(ce), .i_spr_num(num),
      .i_wdata(wd), .i_spr_wr(swr), .i_spr_rd(srd), .i_msr_wr(mwr),
      .i_msr_rd(mrd), .o_rdata(rdata), .o_priv_exc(priv),
      .o_illegal_exc(ill), .i_exc_take(take), .i_exc_pc(pc),
      .i_exc_status(st), .i_exc_new_state(ns), .i_return(ret),
      .o_resume_pc(rpc), .o_resume_valid(rval), .i_data_fault(dflt),
      .i_fault_ea(ea), .i_fault_cause(cause), .i_float_fault(fflt),
      .i_float_cause(fcause), .i_data_valid(dval), .i_data_store(dst),
      .i_data_ea(dea), .o_watch_hit(hit), .i_ext_irq(irq),
      .i_countdown_ack(ack), .o_ext_irq_req(ireq),
      .o_countdown_req(creq), .i_seg_index(seg), .o_seg_desc(segd),
      .o_seg_alt_format(alt), .o_page_table_base(ptb),
      .o_machine_state(ms), .o_ext_target(ext));

   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   // hang guard: the whole run needs well under 5000 cycles
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         fails++;
         end_sim();
      end
   end

   // -------------------------------------------------------------
   // shared tasks
   // -------------------------------------------------------------
   task automatic chk(input logic [64:0] got, input logic [64:0] exp);
      total_checks++;
      if (got !== exp) begin
         fails++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // k: 0 write, 1 read, 2 state write, 3 state read; settled on return
   task automatic op(input int k, input logic [9:0] n, input logic [31:0] d);
      @(posedge clk);
      num <= n;
      wd <= d;
      swr <= (k == 0);
      srd <= (k == 1);
      mwr <= (k == 2);
      mrd <= (k == 3);
      @(posedge clk);
      {swr, srd, mwr, mrd} <= 4'h0;
      #1;
   endtask

   task automatic exc(input logic [31:0] p, input logic [31:0] s,
                      input logic [31:0] n);
      @(posedge clk);
      {take, pc, st, ns} <= {1'b1, p, s, n};
      @(posedge clk);
      take <= 1'b0;
      #1;
   endtask

   task automatic end_sim();
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   // -------------------------------------------------------------
   // scenarios
   // -------------------------------------------------------------
   // plain storage: distinct values expose aliased numbers
   task automatic t_storage();
      logic [9:0] n;
      for (int p = 0; p < 2; p++) begin
         for (int i = 0; i < 37; i++) begin
            n = 10'(i < 4 ? 10'h018 + i : i == 4 ? 10'h013 :
                i < 21 ? 10'h040 + i - 5 : 10'h060 + i - 21);
            op(p, n, {~n[0], 21'h0A5A5, n});
            if (p == 1) chk(rdata, {~n[0], 21'h0A5A5, n});
         end
      end
      chk(ptb, {1'b0, 21'h0A5A5, 10'h013});
      for (int j = 5; j < 7; j++) begin
         @(posedge clk);
         seg <= 4'(j);
         repeat (2) @(posedge clk);
         #1;
         chk(segd, {j[0] == 1'b0, 21'h0A5A5, 10'h060 + j[9:0]});
         chk(alt, j[0] == 1'b0);
      end
   endtask
   task automatic t_ids();
      op(0, 10'h020, 32'hFFFF_FFFF);
      op(1, 10'h020, 32'h0);
      chk(rdata, 32'h0001_0001);
      op(1, 10'h024, 32'h0);
      chk(rdata, 32'h0000_0007);
      op(1, 10'h3FF, 32'h0);
      chk({ill, rdata}, 33'h1_0000_0000);
      op(0, 10'h022, 32'h0000_00C3);
      chk(ext, 32'h0000_00C3);
   endtask
   task automatic t_exc();
      irq <= 1'b1;
      op(2, 10'h0, 32'h0000_8005);
      chk(ireq, 1'b1);
      @(posedge clk);
      {take, pc, st, ns} <= {1'b1, 32'h0000_1234, 32'hABC8_0123, 32'h0};
      @(posedge clk);
      {take, ret} <= 2'h1;
      #1;
      chk(ireq, 1'b0);
      @(posedge clk);
      ret <= 1'b0;
      #1;
      chk({rval, rpc, ms}, {1'b1, 32'h0000_1234, 32'h0000_8005});
      op(1, 10'h015, 32'h0);
      chk(rdata, 32'hABC8_8005);
      exc(32'h0000_2000, 32'h0, 32'h0000_4000);
      op(1, 10'h014, 32'h0);
      chk({priv, rdata}, 33'h1_0000_0000);
      op(1, 10'h01C, 32'h0);
      chk(priv, 1'b0);
      op(2, 10'h0, 32'h0);
      chk({priv, ms}, 33'h1_0000_4000);
      exc(32'h0000_3000, 32'h0, 32'h0);
      irq <= 1'b0;
   endtask
   task automatic t_faults();
      logic [31:0] a;
      @(posedge clk);
      {dflt, fflt, ea, cause, fcause} <=
         {2'h3, 32'h0BAD_0004, 32'h4200_0000, 32'h0000_0011};
      @(posedge clk);
      {dflt, fflt} <= 2'h0;
      op(1, 10'h011, 32'h0);
      chk(rdata, 32'h0BAD_0004);
      op(1, 10'h010, 32'h0);
      chk(rdata, 32'h4200_0000);
      op(1, 10'h021, 32'h0);
      chk(rdata, 32'h0000_0011);
      op(0, 10'h023, 32'h1000_0002);
      for (int s = 1; s >= 0; s--) begin
         @(posedge clk);
         {dval, dst, dea} <= {1'b1, s[0], 32'h1000_0004};
         @(posedge clk);
         dval <= 1'b0;
         #1;
         chk(hit, s[0]);
      end
      op(1, 10'h01C, 32'h0);
      a = rdata;
      op(1, 10'h01C, 32'h0);
      chk(rdata > a, 1'b1);
   endtask
   // pending expiry is held while interrupts are disabled
   task automatic t_timer();
      op(2, 10'h0, 32'h0);
      @(posedge clk);
      ack <= 1'b1;
      @(posedge clk);
      ack <= 1'b0;
      op(0, 10'h012, 32'h0000_0003);
      repeat (40) @(posedge clk);
      chk(creq, 1'b0);
      op(2, 10'h0, 32'h0000_8000);
      chk(creq, 1'b1);
      op(3, 10'h0, 32'h0);
      chk(rdata, 32'h0000_8000);
      @(posedge clk);
      ack <= 1'b1;
      @(posedge clk);
      ack <= 1'b0;
      #1;
      chk(creq, 1'b0);
   endtask
   initial begin
      {rst_n, swr, srd, mwr, mrd, take, ret, dflt, fflt} = 9'h0;
      {dval, dst, irq, ack, num, seg} = 18'h0;
      {wd, pc, st, ns, ea, cause, fcause, dea} = 256'h0;
      {fails, total_checks, cyc} = 0;
      ce = 1'b1;
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      t_storage();
      t_ids();
      t_exc();
      t_faults();
      t_timer();
      end_sim();
   end
endmodule
